// ===== src/scs_host.sv
// Summary of operation
// - Jumpered ack strobes data once selected
// - Host strobe only after seeing ack
// - Strobe tied low keeps output enabled
// - Integrator grounds jumpers to set range
// - Distinct ranges, one card drives
// - Enable held low through power-up
// - Read/write low reads, high writes
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module scs_host (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Card pins
    output logic o_card_enable,
    output logic o_card_write,
    output logic o_output_strobe_n,
    output logic [14:0] o_card_addr,
    output logic [9:0] o_card_wdata,
    input wire logic i_card_selected_ack_n,
    input wire logic [9:0] i_read_data_out
);
    // ======================================================
    // Registers
    // Software view: control word, the operands of the next card cycle and the last read word
    logic [31:0] ctrl; // Go bit always reads back as zero
    logic [14:0] addr; // Card address, upper three bits pick the range
    logic [9:0] wdata; // Word for the next write cycle
    logic [9:0] rdata; // Word captured by the last read cycle
    // Sticky results, cleared once software has seen them
    logic done;
    logic noack;
    // Sequencer state and the one counter that all waits share
    scs_pkg::scs_state_e state;
    logic [7:0] cnt;
    // Every card pin comes from this register, so no pin can glitch
    scs_pkg::scs_card_out_s pins;
    // Read data registered in the setup cycle
    logic [31:0] prdata;
    // ======================================================
    // Bus decode
    // The access phase is the only edge at which a transfer takes effect
    wire access_w = i_psel && i_penable;
    wire wr_w = access_w && i_pwrite;
    // One hit per register
    wire hit_ctrl = i_paddr == scs_pkg::CTRL_OFFSET;
    wire hit_addr = i_paddr == scs_pkg::ADDR_OFFSET;
    wire hit_wdata = i_paddr == scs_pkg::WDATA_OFFSET;
    wire hit_rdata = i_paddr == scs_pkg::RDATA_OFFSET;
    wire hit_status = i_paddr == scs_pkg::STATUS_OFFSET;
    wire mapped = hit_ctrl | hit_addr | hit_wdata | hit_rdata | hit_status;
    // A start is only taken while the sequencer is idle
    wire busy = state != scs_pkg::ST_IDLE;
    wire go = wr_w && hit_ctrl && i_pwdata[scs_pkg::CTRL_GO_BIT] && !busy;
    // Fields of the stored control word steer the running cycle
    wire [1:0] stb_mode = ctrl[scs_pkg::CTRL_STB_MODE_LSB +: 2];
    wire is_write = ctrl[scs_pkg::CTRL_WRITE_BIT];
    wire ack_seen = !i_card_selected_ack_n;
    // Read-back words
    wire [31:0] status_w = {29'h0, noack, done, busy};
    wire [31:0] next_prdata = hit_ctrl ? ctrl : hit_addr ? {17'h0, addr} : hit_wdata ? {22'h0, wdata}
        : hit_rdata ? {22'h0, rdata} : hit_status ? status_w : 32'h0;
    // Outputs, each straight from a register except pready, which is tied high
    assign o_prdata = prdata;
    assign o_pready = 1'b1;
    assign o_card_enable = pins.enable;
    assign o_card_write = pins.write_level;
    assign o_output_strobe_n = pins.strobe_n;
    assign o_card_addr = pins.addr;
    assign o_card_wdata = pins.wdata;
    // Read data registered at setup so it is stable in the access phase
    // Unmapped addresses read zero and raise the error in the access phase
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            prdata <= 32'h0;
            o_pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            o_pslverr <= i_psel && !i_penable && !mapped;
        end
    end
    // Software registers; busy blocks changes to a cycle in flight
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            ctrl <= scs_pkg::CTRL_RESET;
            addr <= 15'h0;
            wdata <= 10'h0;
        end else if (wr_w && !busy) begin
            // Go is stored as zero so a start never repeats by itself
            if (hit_ctrl) ctrl <= {i_pwdata[31:1], 1'b0};
            if (hit_addr) addr <= i_pwdata[14:0];
            if (hit_wdata) wdata <= i_pwdata[9:0];
        end
    end
    // ======================================================
    // Card cycle sequencer; enable stays low from reset
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            state <= scs_pkg::ST_IDLE;
            cnt <= 8'h0;
            pins <= '{enable: 1'b0, write_level: 1'b0, strobe_n: 1'b1, addr: 15'h0, wdata: 10'h0};
            rdata <= 10'h0;
            done <= 1'b0;
            noack <= 1'b0;
        end else begin
            // A status read clears only the flags that its word reported;
            // a flag set at the setup edge was not in the word and survives
            // Later assignments below win, so a set in this cycle stays
            if (access_w && !i_pwrite && hit_status) begin
                if (prdata[scs_pkg::STATUS_DONE_BIT]) done <= 1'b0;
                if (prdata[scs_pkg::STATUS_NOACK_BIT]) noack <= 1'b0;
            end
            unique case (state)
                scs_pkg::ST_IDLE: begin
                    // Latch the operands and the strobe level of the chosen mode
                    if (go) begin
                        pins.addr <= addr;
                        pins.wdata <= wdata;
                        pins.write_level <= i_pwdata[scs_pkg::CTRL_WRITE_BIT];
                        pins.strobe_n <= !(i_pwdata[scs_pkg::CTRL_STB_MODE_LSB +: 2] == scs_pkg::STB_MODE_TIED_LOW);
                        done <= 1'b0;
                        noack <= 1'b0;
                        state <= scs_pkg::ST_SETUP;
                    end
                end
                scs_pkg::ST_SETUP: begin
                    // Address and direction settle one cycle before enable
                    pins.enable <= 1'b1;
                    cnt <= 8'h0;
                    state <= scs_pkg::ST_WAIT_ACK;
                end
                scs_pkg::ST_WAIT_ACK: begin
                    // Count the wait; a card that never answers is given up
                    cnt <= cnt + 8'h1;
                    if (ack_seen) begin
                        // Host strobe only after ack seen
                        if (stb_mode == scs_pkg::STB_MODE_AFTER_ACK && !is_write) pins.strobe_n <= 1'b0;
                        cnt <= 8'h0;
                        state <= scs_pkg::ST_ACCESS;
                    end else if (cnt >= scs_pkg::ACK_CNT) begin
                        // No card claims the range: give up
                        noack <= 1'b1;
                        pins.enable <= 1'b0;
                        // A tied-low strobe must not outlive the cycle
                        pins.strobe_n <= 1'b1;
                        cnt <= 8'h0;
                        state <= scs_pkg::ST_HOLD;
                    end
                end
                scs_pkg::ST_ACCESS: begin
                    cnt <= cnt + 8'h1;
                    // Enable minimum width and strobe lead time both met
                    if (cnt >= scs_pkg::EN_CNT && cnt >= scs_pkg::STB_CNT) begin
                        // Read data is taken while the strobe still stands
                        if (!is_write) rdata <= i_read_data_out;
                        pins.enable <= 1'b0;
                        pins.strobe_n <= 1'b1;
                        cnt <= 8'h0;
                        state <= scs_pkg::ST_HOLD;
                    end
                end
                scs_pkg::ST_HOLD: begin
                    // Address, direction and data held after enable falls
                    cnt <= cnt + 8'h1;
                    if (cnt >= scs_pkg::HOLD_CNT) begin
                        done <= 1'b1;
                        state <= scs_pkg::ST_IDLE;
                    end
                end
                // Unused codes return to idle
                default: state <= scs_pkg::ST_IDLE;
            endcase
        end
    end
    // ======================================================
    // Checks
    a_enable_low_reset: assert property (@(posedge i_sys_clk) !i_resetn |=> !o_card_enable)
        else $error("card enable high after reset");
    a_strobe_after_ack: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        $fell(o_output_strobe_n) && stb_mode == scs_pkg::STB_MODE_AFTER_ACK |-> $past(ack_seen))
        else $error("strobe before acknowledge");
    a_enable_width: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        $rose(o_card_enable) |-> o_card_enable [*6])
        else $error("enable too short");
    a_dir_stable: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        o_card_enable |=> $stable(o_card_write))
        else $error("direction changed in cycle");
    // Steps of a granted access: the ack taken, then enable held throughout
    sequence s_ack_taken;
        state == scs_pkg::ST_WAIT_ACK && ack_seen;
    endsequence
    sequence s_access_run;
        o_card_enable [*7];
    endsequence
    a_access_hold: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        s_ack_taken |=> s_access_run)
        else $error("enable dropped during access");
    a_strobe_at_end: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        $fell(o_card_enable) |-> o_output_strobe_n)
        else $error("strobe still low after enable fell");
    a_strobe_tied_low: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        o_card_enable && stb_mode == scs_pkg::STB_MODE_TIED_LOW |-> !o_output_strobe_n)
        else $error("tied strobe high during cycle");
    a_strobe_jumper: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        stb_mode == scs_pkg::STB_MODE_JUMPER |-> o_output_strobe_n)
        else $error("host strobe driven in jumper mode");
endmodule : scs_host
`default_nettype wire

// ===== src/scs_pkg.sv
package scs_pkg;
    // ======================================================
    // Register map of the controller (APB, byte addresses)
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] ADDR_OFFSET = 8'h04;
    localparam logic [7:0] WDATA_OFFSET = 8'h08;
    localparam logic [7:0] RDATA_OFFSET = 8'h0c;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;
    // ======================================================
    // Control fields
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_STB_MODE_LSB = 4;
    // Strobe modes
    localparam logic [1:0] STB_MODE_JUMPER = 2'h0;
    localparam logic [1:0] STB_MODE_AFTER_ACK = 2'h1;
    localparam logic [1:0] STB_MODE_TIED_LOW = 2'h2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Status fields
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_DONE_BIT = 1;
    localparam int STATUS_NOACK_BIT = 2;
    // ======================================================
    // Widths
    localparam int ADDR_W = 15;
    localparam int DATA_W = 10;
    // ======================================================
    // Timing, the slowest card variant
    localparam int CLK_MHZ = 10;
    localparam int EN_MIN_NS = 600;
    localparam int HOLD_MIN_NS = 600;
    localparam int STB_LEAD_NS = 100;
    localparam int ACK_WAIT_NS = 2000;
    localparam int EN_CYC = (EN_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC = (HOLD_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int STB_CYC = (STB_LEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int ACK_CYC = (ACK_WAIT_NS * CLK_MHZ) / 1000;
    localparam logic [7:0] EN_CNT = 8'(EN_CYC);
    localparam logic [7:0] HOLD_CNT = 8'(HOLD_CYC);
    localparam logic [7:0] STB_CNT = 8'(STB_CYC);
    localparam logic [7:0] ACK_CNT = 8'(ACK_CYC);
    // ======================================================
    // Card-side pin group driven by the controller
    typedef struct packed {
        logic enable;
        logic write_level;
        logic strobe_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } scs_card_out_s;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_WAIT_ACK = 3'b010,
        ST_ACCESS = 3'b011,
        ST_HOLD = 3'b100
    } scs_state_e;
endpackage : scs_pkg

// ===== verification/scs_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// Behavioural storage card: range decode, array, gated read data
module scs_card_model #(
    // Jumper levels, bit set means left open (high)
    parameter logic [2:0] RANGE_SEL = 3'h5
) (
    // Pins driven by the host controller
    input wire logic i_enable,
    input wire logic i_write,
    input wire logic i_strobe_n,
    input wire logic [14:0] i_addr,
    input wire logic [9:0] i_wdata,
    // Pins driven by the card
    output logic o_ack_n,
    output logic [9:0] o_data
);
    logic [9:0] mem [0:4095]; // Full 4096-word population
    // Each of address bits 14 to 12 must differ from its jumper; grounded jumpers add their weight
    wire logic sel = i_enable && ((i_addr[14:12] ^ RANGE_SEL) == 3'h7);
    wire logic drive = sel && !i_write && !i_strobe_n;
    assign o_ack_n = !sel;
    // Released bus shows the inverse so a stale value never passes
    assign o_data = drive ? mem[i_addr[11:0]] : ~mem[i_addr[11:0]];
    // Write straight through while selected with the write level high
    always @(sel, i_write, i_addr, i_wdata) begin
        if (sel && i_write) begin
            mem[i_addr[11:0]] = i_wdata;
        end
    end
endmodule : scs_card_model
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ======================================================
    // Bench signals
    logic clk, rstn, psel, pen, pwr, err, prdy, perr, en, wr, stb_n, ack_n, jmp;
    logic [7:0] pa;
    logic [31:0] pwd, prd, rd;
    logic [14:0] ca;
    logic [9:0] cwd, cdo;
    int mismatches, compares;
    // Jumper mode ties the acknowledge back onto the strobe
    wire logic cstb_n = jmp ? ack_n : stb_n;
    scs_host dut (.i_sys_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
        .o_card_enable(en), .o_card_write(wr), .o_output_strobe_n(stb_n), .o_card_addr(ca),
        .o_card_wdata(cwd), .i_card_selected_ack_n(ack_n), .i_read_data_out(cdo));
    scs_card_model card (.i_enable(en), .i_write(wr), .i_strobe_n(cstb_n), .i_addr(ca),
        .i_wdata(cwd), .o_ack_n(ack_n), .o_data(cdo));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ======================================================
    // Shared tasks
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Setup, access, then hold until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        rd = prd;
        err = perr;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb
    // One card cycle, then poll status until done (bounded)
    task cyc(input logic [1:0] m, input logic w, input logic [14:0] a, input logic [9:0] d, input logic na);
        int n;
        logic na_seen;
        n = 0;
        na_seen = 1'b0;
        apb(1'b1, scs_pkg::ADDR_OFFSET, 32'(a));
        apb(1'b1, scs_pkg::WDATA_OFFSET, 32'(d));
        apb(1'b1, scs_pkg::CTRL_OFFSET, (32'(m) << scs_pkg::CTRL_STB_MODE_LSB) | (32'(w) << scs_pkg::CTRL_WRITE_BIT) | 32'h1);
        do begin
            apb(1'b0, scs_pkg::STATUS_OFFSET, 32'h0);
            // The read that reports noack also clears it
            na_seen = na_seen | rd[scs_pkg::STATUS_NOACK_BIT];
            n++;
        end while (rd[scs_pkg::STATUS_DONE_BIT] !== 1'b1 && n < 100);
        chk("done", 32'h1, 32'(rd[scs_pkg::STATUS_DONE_BIT]));
        chk("noack", 32'(na), 32'(na_seen));
    endtask : cyc
    // ======================================================
    // Scenarios; card range index 2 answers at 8k to 12k
    task t_write_read;
        cyc(scs_pkg::STB_MODE_AFTER_ACK, 1'b1, 15'h2123, 10'h2a5, 1'b0);
        cyc(scs_pkg::STB_MODE_AFTER_ACK, 1'b0, 15'h2123, 10'h000, 1'b0);
        apb(1'b0, scs_pkg::RDATA_OFFSET, 32'h0);
        chk("rdata_ack", 32'h2a5, rd);
        apb(1'b0, scs_pkg::CTRL_OFFSET, 32'h0);
        chk("ctrl_readback", 32'(scs_pkg::STB_MODE_AFTER_ACK) << scs_pkg::CTRL_STB_MODE_LSB, rd);
    endtask : t_write_read
    task t_modes;
        cyc(scs_pkg::STB_MODE_AFTER_ACK, 1'b1, 15'h2fff, 10'h15a, 1'b0);
        jmp <= 1'b1;
        cyc(scs_pkg::STB_MODE_JUMPER, 1'b0, 15'h2fff, 10'h000, 1'b0);
        apb(1'b0, scs_pkg::RDATA_OFFSET, 32'h0);
        chk("rdata_jumper", 32'h15a, rd);
        jmp <= 1'b0;
        cyc(scs_pkg::STB_MODE_TIED_LOW, 1'b0, 15'h2fff, 10'h000, 1'b0);
        apb(1'b0, scs_pkg::RDATA_OFFSET, 32'h0);
        chk("rdata_tied", 32'h15a, rd);
    endtask : t_modes
    // One address bit matches its jumper, so no card answers
    task t_noack;
        cyc(scs_pkg::STB_MODE_AFTER_ACK, 1'b0, 15'h3123, 10'h000, 1'b1);
    endtask : t_noack
    task t_unmapped;
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        chk("unmapped", 32'h0, rd);
    endtask : t_unmapped
    // A write while busy is ignored, and reset in mid-cycle drops enable
    task t_reset_mid;
        apb(1'b1, scs_pkg::CTRL_OFFSET, 32'h1);
        apb(1'b1, scs_pkg::ADDR_OFFSET, 32'h0456);
        apb(1'b0, scs_pkg::ADDR_OFFSET, 32'h0);
        chk("addr_busy", 32'h3123, rd);
        chk("pin_addr", 32'h3123, 32'(ca));
        chk("pin_enable", 32'h1, 32'(en));
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("enable_mid_reset", 32'h0, 32'(en));
        apb(1'b0, scs_pkg::STATUS_OFFSET, 32'h0);
        chk("status_mid_reset", 32'h0, rd);
    endtask : t_reset_mid
    task summarize;
        if (mismatches == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    // ======================================================
    // Main sequence and watchdog
    initial begin
        psel = 1'b0; pen = 1'b0; pwr = 1'b0; pa = 8'h00; pwd = 32'h0; jmp = 1'b0; rstn = 1'b0;
        mismatches = 0;
        compares = 0;
        repeat (8) @(posedge clk);
        chk("enable_reset", 32'h0, 32'(en));
        rstn <= 1'b1;
        t_write_read;
        t_modes;
        t_noack;
        t_unmapped;
        t_reset_mid;
        summarize;
    end
    initial begin
        #3000000;
        mismatches++;
        summarize;
    end
endmodule : tb_top
`default_nettype wire
